/* rtl/bst_pkg.sv */
// Constants, opcodes and state codes shared by the scan port modules
// Contract
// (RQ1) All port sampling and output updates are timed from the test clock only.
// (RQ2) Mode select and data in are captured on each test clock rising edge.
// (RQ3) Data out changes on each test clock falling edge, for sampling at the next rise.
// (RQ4) Port signals take over the shared pins only while test select is asserted.
// (RQ5) Opcodes all-zeros and all-ones select bypass; the sample opcode selects sample/preload.
// (RQ6) External test drives pins from boundary cells; clamp and high-z select bypass.
// (RQ7) Identification opcode shifts a fixed 32-bit code; private opcode selects internal register.
// (RQ8) Four signals, a controller state machine, instruction register and data register array.
// (RQ9) Every digital I/O pin has a boundary cell; analog and crystal pins have none. Here the four shared port pins have no cell.
// (RQ10) Controller states and register behaviour follow the 2001 boundary-scan standard.
// (RQ11) Data out is driven only in shift states and is high impedance otherwise.
package bst_pkg;
   localparam int unsigned IR_W = 16;
   localparam logic [15:0] OP_BYPASS0 = 16'h0000;
   localparam logic [15:0] OP_BYPASS1 = 16'hffff;
   localparam logic [15:0] OP_SAMPLE = 16'hfff8;
   localparam logic [15:0] OP_EXTEST = 16'hffe8;
   localparam logic [15:0] OP_CLAMP = 16'hffef;
   localparam logic [15:0] OP_IDCODE = 16'hfffe;
   localparam logic [15:0] OP_HIGHZ = 16'hffcf;
   localparam logic [15:0] OP_INTERNAL_DATA_REGISTER_SELECT = 16'hfffd;
   // Standard capture pattern, low two bits 01
   localparam logic [15:0] IR_CAPTURE = 16'h0001;
   localparam logic [15:0] IR_RESET = OP_IDCODE;
   // Arbitrary identification value; bit 0 must stay set
   localparam logic [31:0] IDCODE_DEFAULT = 32'h0a5a_5001;
   localparam int unsigned ID_W = 32;
   localparam int unsigned INT_DR_W = 8;
   localparam logic [7:0] INT_DR_RESET = 8'h00;
   localparam int unsigned SYNC_STAGES = 2;
   // Bit positions of the sampled port lines
   localparam int unsigned SYN_TCK = 0;
   localparam int unsigned SYN_TMS = 1;
   localparam int unsigned SYN_TDI = 2;
   localparam int unsigned SYN_TMODE = 3;
   localparam int unsigned SYN_W = 4;
   // Shared pin positions
   localparam int unsigned PIN_TCK = 0;
   localparam int unsigned PIN_TMS = 1;
   localparam int unsigned PIN_TDI = 2;
   localparam int unsigned PIN_TDO = 3;
   localparam int unsigned PIN_W = 4;
   // Boundary cell layout per digital pin
   localparam int unsigned CELL_IN = 0;
   localparam int unsigned CELL_OUT = 1;
   localparam int unsigned CELL_OE = 2;
   localparam int unsigned CELL_W = 3;
   localparam int unsigned NUM_IO = 8;

   typedef enum logic [3:0] {
      ST_RESET = 4'h0,
      ST_IDLE = 4'h1,
      ST_SEL_DR = 4'h2,
      ST_CAP_DR = 4'h3,
      ST_SHIFT_DR = 4'h4,
      ST_EXIT1_DR = 4'h5,
      ST_PAUSE_DR = 4'h6,
      ST_EXIT2_DR = 4'h7,
      ST_UPD_DR = 4'h8,
      ST_SEL_IR = 4'h9,
      ST_CAP_IR = 4'ha,
      ST_SHIFT_IR = 4'hb,
      ST_EXIT1_IR = 4'hc,
      ST_PAUSE_IR = 4'hd,
      ST_EXIT2_IR = 4'he,
      ST_UPD_IR = 4'hf
   } bst_state_t;

   typedef enum logic [1:0] {
      DR_BYPASS = 2'h0,
      DR_BOUNDARY = 2'h1,
      DR_IDCODE = 2'h2,
      DR_INTERNAL = 2'h3
   } bst_dr_sel_t;
endpackage

/* rtl/bst_tap_if.sv */
// Edge and state signals passed between the scan port modules
`timescale 1ns/1ps
interface bst_tap_if;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   logic test_mode;
   bst_pkg::bst_state_t state;

   modport sync_mp (output tck_rise, output tck_fall, output tms, output tdi, output test_mode);
   modport fsm_mp (input tck_rise, input tms, input test_mode, output state);
   modport core_mp (input tck_rise, input tck_fall, input tdi, input test_mode, input state);
endinterface

/* rtl/bst_sync.sv */
// Two-stage synchroniser of the port lines and test clock edge finder
`timescale 1ns/1ps
module bst_sync
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [bst_pkg::SYN_W-1:0] raw_i,
   bst_tap_if.sync_mp tap
);
   logic [bst_pkg::SYN_W-1:0] meta_r;
   logic [bst_pkg::SYN_W-1:0] sync_r;
   logic [bst_pkg::SYN_W-1:0] meta_nxt;
   logic [bst_pkg::SYN_W-1:0] sync_nxt;
   logic tck_old_r;
   logic tck_old_nxt;

   genvar gi;
   generate
      for (gi = 0; gi < bst_pkg::SYN_W; gi++)
      begin : g_sync
         always_comb
         begin
            meta_nxt[gi] = raw_i[gi];
            sync_nxt[gi] = meta_r[gi];
         end

         always_ff @(posedge clk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
            begin
               meta_r[gi] <= 1'b0;
               sync_r[gi] <= 1'b0;
            end
            else
            begin
               meta_r[gi] <= meta_nxt[gi];
               sync_r[gi] <= sync_nxt[gi];
            end
         end
      end
   endgenerate

   always_comb
   begin
      tck_old_nxt = sync_r[bst_pkg::SYN_TCK];
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         tck_old_r <= 1'b0;
      else
         tck_old_r <= tck_old_nxt;
   end

   // Lines pass the same two stages, so their skew against the clock edge is kept [RQ1]
   assign tap.tck_rise = sync_r[bst_pkg::SYN_TCK] & ~tck_old_r;
   assign tap.tck_fall = ~sync_r[bst_pkg::SYN_TCK] & tck_old_r;
   assign tap.tms = sync_r[bst_pkg::SYN_TMS];
   assign tap.tdi = sync_r[bst_pkg::SYN_TDI];
   assign tap.test_mode = sync_r[bst_pkg::SYN_TMODE];
endmodule

/* rtl/bst_fsm.sv */
// Test port controller state machine, stepped on test clock rising edges
`timescale 1ns/1ps
module bst_fsm
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   bst_tap_if.fsm_mp tap
);
   bst_pkg::bst_state_t state_r;
   bst_pkg::bst_state_t state_nxt;
   bst_pkg::bst_state_t step;

   // Standard sixteen-state walk on mode select [RQ10]
   always_comb
   begin
      unique case (state_r)
         bst_pkg::ST_RESET: step = tap.tms ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE: step = tap.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_DR: step = tap.tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR: step = tap.tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_SHIFT_DR: step = tap.tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_EXIT1_DR: step = tap.tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAUSE_DR;
         bst_pkg::ST_PAUSE_DR: step = tap.tms ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
         bst_pkg::ST_EXIT2_DR: step = tap.tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_UPD_DR: step = tap.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_IR: step = tap.tms ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR: step = tap.tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_SHIFT_IR: step = tap.tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_EXIT1_IR: step = tap.tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAUSE_IR;
         bst_pkg::ST_PAUSE_IR: step = tap.tms ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
         bst_pkg::ST_EXIT2_IR: step = tap.tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_UPD_IR: step = tap.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      endcase
   end

   always_comb
   begin
      state_nxt = state_r;
      // No reset pin on the port, so leaving test mode parks the controller
      if (!tap.test_mode)
         state_nxt = bst_pkg::ST_RESET;
      else if (tap.tck_rise)
         state_nxt = step; // [RQ2]
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         state_r <= bst_pkg::ST_RESET;
      else
         state_r <= state_nxt;
   end

   assign tap.state = state_r;
endmodule

/* rtl/bst_tap.sv */
// Boundary-scan test port top: pin sharing, instruction decode and data registers
`timescale 1ns/1ps
module bst_tap
#(
   parameter int unsigned NUM_IO = bst_pkg::NUM_IO,
   parameter logic [31:0] IDCODE = bst_pkg::IDCODE_DEFAULT
)
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic test_mode_i,
   input wire logic [bst_pkg::PIN_W-1:0] shared_pin_in_i,
   output logic [bst_pkg::PIN_W-1:0] shared_pin_out_o,
   output logic [bst_pkg::PIN_W-1:0] shared_pin_oe_b_o,
   input wire logic [bst_pkg::PIN_W-1:0] func_out_i,
   input wire logic [bst_pkg::PIN_W-1:0] func_oe_b_i,
   output logic [bst_pkg::PIN_W-1:0] func_in_o,
   input wire logic [NUM_IO-1:0] core_out_i,
   input wire logic [NUM_IO-1:0] core_oe_b_i,
   output logic [NUM_IO-1:0] core_in_o,
   input wire logic [NUM_IO-1:0] pad_in_i,
   output logic [NUM_IO-1:0] pad_out_o,
   output logic [NUM_IO-1:0] pad_oe_b_o,
   output logic [bst_pkg::INT_DR_W-1:0] internal_dr_o,
   output logic internal_data_register_select_o
);
   localparam int unsigned BSR_W = bst_pkg::CELL_W * NUM_IO;

   bst_tap_if tap ();

   logic [bst_pkg::SYN_W-1:0] port_raw;
   logic [NUM_IO-1:0] pad_meta_r;
   logic [NUM_IO-1:0] pad_sync_r;
   logic [BSR_W-1:0] bsr_capture;

   logic [bst_pkg::IR_W-1:0] ir_r;
   logic [bst_pkg::IR_W-1:0] ir_nxt;
   logic [bst_pkg::IR_W-1:0] ir_shift_r;
   logic [bst_pkg::IR_W-1:0] ir_shift_nxt;
   logic bypass_r;
   logic bypass_nxt;
   logic [bst_pkg::ID_W-1:0] id_shift_r;
   logic [bst_pkg::ID_W-1:0] id_shift_nxt;
   logic [BSR_W-1:0] bsr_shift_r;
   logic [BSR_W-1:0] bsr_shift_nxt;
   logic [BSR_W-1:0] bsr_upd_r;
   logic [BSR_W-1:0] bsr_upd_nxt;
   logic [bst_pkg::INT_DR_W-1:0] int_shift_r;
   logic [bst_pkg::INT_DR_W-1:0] int_shift_nxt;
   logic [bst_pkg::INT_DR_W-1:0] int_dr_r;
   logic [bst_pkg::INT_DR_W-1:0] int_dr_nxt;
   logic tdo_r;
   logic tdo_nxt;
   logic tdo_oe_b_r;
   logic tdo_oe_b_nxt;

   bst_pkg::bst_dr_sel_t dr_sel;
   logic pads_from_cells;
   logic pads_highz;
   logic dr_lsb;

   // The port lines are read from the shared pins themselves [RQ8]
   assign port_raw[bst_pkg::SYN_TCK] = shared_pin_in_i[bst_pkg::PIN_TCK];
   assign port_raw[bst_pkg::SYN_TMS] = shared_pin_in_i[bst_pkg::PIN_TMS];
   assign port_raw[bst_pkg::SYN_TDI] = shared_pin_in_i[bst_pkg::PIN_TDI];
   assign port_raw[bst_pkg::SYN_TMODE] = test_mode_i;

   bst_sync u_sync
   (
      .clk_i (clk_i),
      .rst_b_i (rst_b_i),
      .raw_i (port_raw),
      .tap (tap.sync_mp)
   );

   bst_fsm u_fsm
   (
      .clk_i (clk_i),
      .rst_b_i (rst_b_i),
      .tap (tap.fsm_mp)
   );

   // One cell group per pad pin; the four shared port pins, crystal and analog pins are not in this list [RQ9]
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IO; gi++)
      begin : g_cell
         always_ff @(posedge clk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
            begin
               pad_meta_r[gi] <= 1'b0;
               pad_sync_r[gi] <= 1'b0;
            end
            else
            begin
               pad_meta_r[gi] <= pad_in_i[gi];
               pad_sync_r[gi] <= pad_meta_r[gi];
            end
         end

         assign bsr_capture[gi*bst_pkg::CELL_W+bst_pkg::CELL_IN] = pad_sync_r[gi];
         assign bsr_capture[gi*bst_pkg::CELL_W+bst_pkg::CELL_OUT] = core_out_i[gi];
         assign bsr_capture[gi*bst_pkg::CELL_W+bst_pkg::CELL_OE] = core_oe_b_i[gi];

         always_comb
         begin
            if (pads_highz)
            begin
               pad_out_o[gi] = 1'b0;
               pad_oe_b_o[gi] = 1'b1; // [RQ6]
            end
            else if (pads_from_cells)
            begin
               pad_out_o[gi] = bsr_upd_r[gi*bst_pkg::CELL_W+bst_pkg::CELL_OUT]; // [RQ6]
               pad_oe_b_o[gi] = bsr_upd_r[gi*bst_pkg::CELL_W+bst_pkg::CELL_OE];
            end
            else
            begin
               pad_out_o[gi] = core_out_i[gi];
               pad_oe_b_o[gi] = core_oe_b_i[gi];
            end
         end
      end
   endgenerate

   assign core_in_o = pad_in_i;

   // Unknown opcodes fall back to bypass, as the standard requires
   always_comb
   begin
      unique case (ir_r)
         bst_pkg::OP_BYPASS0, bst_pkg::OP_BYPASS1: dr_sel = bst_pkg::DR_BYPASS; // [RQ5]
         bst_pkg::OP_SAMPLE, bst_pkg::OP_EXTEST: dr_sel = bst_pkg::DR_BOUNDARY; // [RQ5] [RQ6]
         bst_pkg::OP_CLAMP, bst_pkg::OP_HIGHZ: dr_sel = bst_pkg::DR_BYPASS; // [RQ6]
         bst_pkg::OP_IDCODE: dr_sel = bst_pkg::DR_IDCODE; // [RQ7]
         bst_pkg::OP_INTERNAL_DATA_REGISTER_SELECT: dr_sel = bst_pkg::DR_INTERNAL; // [RQ7]
         default: dr_sel = bst_pkg::DR_BYPASS;
      endcase
   end

   // Pin control follows the active instruction only while in test mode [RQ4]
   assign pads_from_cells = tap.test_mode && (ir_r == bst_pkg::OP_EXTEST || ir_r == bst_pkg::OP_CLAMP);
   assign pads_highz = tap.test_mode && (ir_r == bst_pkg::OP_HIGHZ);

   always_comb
   begin
      unique case (dr_sel)
         bst_pkg::DR_BYPASS: dr_lsb = bypass_r;
         bst_pkg::DR_BOUNDARY: dr_lsb = bsr_shift_r[0];
         bst_pkg::DR_IDCODE: dr_lsb = id_shift_r[0];
         bst_pkg::DR_INTERNAL: dr_lsb = int_shift_r[0];
      endcase
   end

   // Capture and shift on the rising edge, updates on the falling edge [RQ10]
   always_comb
   begin
      ir_nxt = ir_r;
      ir_shift_nxt = ir_shift_r;
      bypass_nxt = bypass_r;
      id_shift_nxt = id_shift_r;
      bsr_shift_nxt = bsr_shift_r;
      bsr_upd_nxt = bsr_upd_r;
      int_shift_nxt = int_shift_r;
      int_dr_nxt = int_dr_r;
      if (tap.state == bst_pkg::ST_RESET)
         ir_nxt = bst_pkg::IR_RESET; // [RQ10]
      if (tap.tck_rise)
      begin
         unique case (tap.state)
            bst_pkg::ST_CAP_IR: ir_shift_nxt = bst_pkg::IR_CAPTURE;
            bst_pkg::ST_SHIFT_IR: ir_shift_nxt = {tap.tdi, ir_shift_r[bst_pkg::IR_W-1:1]}; // [RQ2]
            bst_pkg::ST_CAP_DR:
            begin
               unique case (dr_sel)
                  bst_pkg::DR_BYPASS: bypass_nxt = 1'b0;
                  bst_pkg::DR_BOUNDARY: bsr_shift_nxt = bsr_capture;
                  bst_pkg::DR_IDCODE: id_shift_nxt = IDCODE; // [RQ7]
                  bst_pkg::DR_INTERNAL: int_shift_nxt = int_dr_r;
               endcase
            end
            bst_pkg::ST_SHIFT_DR:
            begin
               unique case (dr_sel)
                  bst_pkg::DR_BYPASS: bypass_nxt = tap.tdi; // [RQ2] [RQ5]
                  bst_pkg::DR_BOUNDARY: bsr_shift_nxt = {tap.tdi, bsr_shift_r[BSR_W-1:1]};
                  bst_pkg::DR_IDCODE: id_shift_nxt = {tap.tdi, id_shift_r[bst_pkg::ID_W-1:1]};
                  bst_pkg::DR_INTERNAL: int_shift_nxt = {tap.tdi, int_shift_r[bst_pkg::INT_DR_W-1:1]};
               endcase
            end
            default:
            begin
            end
         endcase
      end
      if (tap.tck_fall)
      begin
         if (tap.state == bst_pkg::ST_UPD_IR)
            ir_nxt = ir_shift_r;
         if (tap.state == bst_pkg::ST_UPD_DR && dr_sel == bst_pkg::DR_BOUNDARY)
            bsr_upd_nxt = bsr_shift_r; // Preload for sample, live drive for external test
         if (tap.state == bst_pkg::ST_UPD_DR && dr_sel == bst_pkg::DR_INTERNAL)
            int_dr_nxt = int_shift_r;
      end
   end

   // Data out moves only on the falling edge, giving the tester half a period [RQ3]
   always_comb
   begin
      tdo_nxt = tdo_r;
      tdo_oe_b_nxt = tdo_oe_b_r;
      if (!tap.test_mode)
      begin
         tdo_nxt = 1'b0;
         tdo_oe_b_nxt = 1'b1;
      end
      else if (tap.tck_fall)
      begin
         unique case (tap.state)
            bst_pkg::ST_SHIFT_IR:
            begin
               tdo_nxt = ir_shift_r[0]; // [RQ3]
               tdo_oe_b_nxt = 1'b0; // [RQ11]
            end
            bst_pkg::ST_SHIFT_DR:
            begin
               tdo_nxt = dr_lsb; // [RQ3]
               tdo_oe_b_nxt = 1'b0; // [RQ11]
            end
            default:
            begin
               tdo_oe_b_nxt = 1'b1; // [RQ11]
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ir_r <= bst_pkg::IR_RESET;
         ir_shift_r <= bst_pkg::IR_CAPTURE;
         bypass_r <= 1'b0;
         id_shift_r <= '0;
         bsr_shift_r <= '0;
         bsr_upd_r <= '0;
         int_shift_r <= bst_pkg::INT_DR_RESET;
         int_dr_r <= bst_pkg::INT_DR_RESET;
         tdo_r <= 1'b0;
         tdo_oe_b_r <= 1'b1;
      end
      else
      begin
         ir_r <= ir_nxt;
         ir_shift_r <= ir_shift_nxt;
         bypass_r <= bypass_nxt;
         id_shift_r <= id_shift_nxt;
         bsr_shift_r <= bsr_shift_nxt;
         bsr_upd_r <= bsr_upd_nxt;
         int_shift_r <= int_shift_nxt;
         int_dr_r <= int_dr_nxt;
         tdo_r <= tdo_nxt;
         tdo_oe_b_r <= tdo_oe_b_nxt;
      end
   end

   // Shared pins: port lines replace the normal functions in test mode [RQ4]
   always_comb
   begin
      if (tap.test_mode)
      begin
         shared_pin_out_o = '0;
         shared_pin_oe_b_o = '1;
         shared_pin_out_o[bst_pkg::PIN_TDO] = tdo_r;
         shared_pin_oe_b_o[bst_pkg::PIN_TDO] = tdo_oe_b_r;
         func_in_o = '0;
      end
      else
      begin
         shared_pin_out_o = func_out_i;
         shared_pin_oe_b_o = func_oe_b_i;
         func_in_o = shared_pin_in_i;
      end
   end

   assign internal_dr_o = int_dr_r;
   assign internal_data_register_select_o = tap.test_mode && (dr_sel == bst_pkg::DR_INTERNAL);
endmodule

/* verification/bst_tap_sva.sv */
// Checker of pin sharing and test clock timing at the scan port top
`timescale 1ns/1ps
module bst_tap_sva
#(
   parameter int unsigned NUM_IO = 8
)
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic test_mode_i,
   input wire logic [bst_pkg::PIN_W-1:0] shared_pin_in_i,
   input wire logic [bst_pkg::PIN_W-1:0] shared_pin_out_o,
   input wire logic [bst_pkg::PIN_W-1:0] shared_pin_oe_b_o,
   input wire logic [bst_pkg::PIN_W-1:0] func_out_i,
   input wire logic [bst_pkg::PIN_W-1:0] func_oe_b_i,
   input wire logic [bst_pkg::PIN_W-1:0] func_in_o,
   input wire logic [NUM_IO-1:0] core_out_i,
   input wire logic [NUM_IO-1:0] core_oe_b_i,
   input wire logic [NUM_IO-1:0] pad_out_o,
   input wire logic [NUM_IO-1:0] pad_oe_b_o,
   input wire logic [bst_pkg::INT_DR_W-1:0] internal_dr_o,
   input wire logic internal_data_register_select_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Test select passes two flops, so both views look back two cycles
   sequence s_on;
      test_mode_i && $past(test_mode_i, 1) && $past(test_mode_i, 2) && $past(rst_b_i, 1) && $past(rst_b_i, 2);
   endsequence
   sequence s_off;
      !test_mode_i && !$past(test_mode_i, 1) && !$past(test_mode_i, 2);
   endsequence
   property p_func_pass;
      s_off |-> shared_pin_out_o == func_out_i && shared_pin_oe_b_o == func_oe_b_i && func_in_o == shared_pin_in_i;
   endproperty
   a_func_pass: assert property (p_func_pass) else $error("shared pins not on normal function");
   property p_test_pins;
      s_on |-> shared_pin_oe_b_o[2:0] == 3'h7 && shared_pin_out_o[2:0] == 3'h0 && func_in_o == 4'h0;
   endproperty
   a_test_pins: assert property (p_test_pins) else $error("shared pins not handed to test port");
   property p_pads_core;
      s_off |-> pad_out_o == core_out_i && pad_oe_b_o == core_oe_b_i;
   endproperty
   a_pads_core: assert property (p_pads_core) else $error("pads not driven by core");
   property p_tdo_edge;
      // Previous sample must also be in test mode, or the hand-over from the normal pin drive counts as a move
      s_on ##0 $past(test_mode_i, 3) && $changed(shared_pin_out_o[3]) |->
         !shared_pin_in_i[0] && !$past(shared_pin_in_i[0], 3);
   endproperty
   a_tdo_edge: assert property (p_tdo_edge) else $error("data out moved away from clock fall");
   property p_oe_edge;
      s_on ##0 $past(test_mode_i, 3) && $changed(shared_pin_oe_b_o[3]) |->
         !shared_pin_in_i[0] && !$past(shared_pin_in_i[0], 3);
   endproperty
   a_oe_edge: assert property (p_oe_edge) else $error("data out enable moved off clock fall");
   property p_sel_mode;
      internal_data_register_select_o |-> $past(test_mode_i, 2);
   endproperty
   a_sel_mode: assert property (p_sel_mode) else $error("private select without test select");
   property p_sel_off;
      s_off |-> !internal_data_register_select_o;
   endproperty
   a_sel_off: assert property (p_sel_off) else $error("private select outside test mode");
   property p_intdr_edge;
      $changed(internal_dr_o) |-> !shared_pin_in_i[0] && !$past(shared_pin_in_i[0], 2);
   endproperty
   a_intdr_edge: assert property (p_intdr_edge) else $error("internal register moved off clock fall");
endmodule

bind bst_tap bst_tap_sva #(.NUM_IO(NUM_IO)) bst_tap_sva_inst
(
   .clk_i(clk_i),
   .rst_b_i(rst_b_i),
   .test_mode_i(test_mode_i),
   .shared_pin_in_i(shared_pin_in_i),
   .shared_pin_out_o(shared_pin_out_o),
   .shared_pin_oe_b_o(shared_pin_oe_b_o),
   .func_out_i(func_out_i),
   .func_oe_b_i(func_oe_b_i),
   .func_in_o(func_in_o),
   .core_out_i(core_out_i),
   .core_oe_b_i(core_oe_b_i),
   .pad_out_o(pad_out_o),
   .pad_oe_b_o(pad_oe_b_o),
   .internal_dr_o(internal_dr_o),
   .internal_data_register_select_o(internal_data_register_select_o)
);

/* verification/bst_tester.sv */
// Tester model driving the scan port's clock, mode select and data in
`timescale 1ns/1ps
module bst_tester
(
   input wire logic clk_i,
   input wire logic tdo_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   initial
   begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   // Low 5 clk, high 3: data out has settled before it is taken at the rise
   task automatic step(input logic m, input logic d, output logic q);
      @(posedge clk_i);
      tck_o <= 1'b0;
      tms_o <= m;
      tdi_o <= d;
      repeat (5) @(posedge clk_i);
      q = tdo_i;
      tck_o <= 1'b1;
      repeat (2) @(posedge clk_i);
   endtask
   // From idle to shift, n bits LSB first, then update and back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] v, output logic [31:0] cap);
      logic q;
      cap = 32'h0;
      step(1'b1, 1'b0, q);
      if (ir)
         step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, v[i], q);
         cap[i] = q;
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
endmodule

/* verification/bst_tap_bench.sv */
// Self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
module bst_tap_bench;
   // Arbitrary identification value, bit 0 set
   localparam logic [31:0] ID_VAL = 32'h2468_ace1;
   localparam logic [23:0] PAT = 24'h6d_b24e;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic test_mode = 1'b0;
   logic [3:0] func_out = 4'h9;
   logic [3:0] func_oe_b = 4'h6;
   logic [7:0] core_out = 8'ha5;
   logic [7:0] core_oe_b = 8'h0f;
   logic [7:0] pad_in = 8'h3c;
   logic [3:0] pin_out;
   logic [3:0] pin_oe_b;
   logic [3:0] func_in;
   logic [7:0] core_in;
   logic [7:0] pad_out;
   logic [7:0] pad_oe_b;
   logic [7:0] int_dr;
   logic int_sel;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo_last = 1'b0;
   logic tdo_line;
   int failures = 0;
   int total_checks = 0;
   always #10 clk = ~clk;
   always @(posedge clk) tdo_last <= tdo_line;
   // Released data-out line toggles, so a stale level never passes for data
   assign tdo_line = (pin_oe_b[3] === 1'b0) ? pin_out[3] : ~tdo_last;
   bst_tap #(.IDCODE(ID_VAL)) bst_tap_inst
   (
      .clk_i(clk),
      .rst_b_i(rst_b),
      .test_mode_i(test_mode),
      .shared_pin_in_i({tdo_line, tdi, tms, tck}),
      .shared_pin_out_o(pin_out),
      .shared_pin_oe_b_o(pin_oe_b),
      .func_out_i(func_out),
      .func_oe_b_i(func_oe_b),
      .func_in_o(func_in),
      .core_out_i(core_out),
      .core_oe_b_i(core_oe_b),
      .core_in_o(core_in),
      .pad_in_i(pad_in),
      .pad_out_o(pad_out),
      .pad_oe_b_o(pad_oe_b),
      .internal_dr_o(int_dr),
      .internal_data_register_select_o(int_sel)
   );
   bst_tester bst_tester_inst
   (
      .clk_i(clk),
      .tdo_i(tdo_line),
      .tck_o(tck),
      .tms_o(tms),
      .tdi_o(tdi)
   );
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic t_normal();
      #1;
      chk(pin_out, func_out);
      chk(pin_oe_b, func_oe_b);
      chk(func_in, {tdo_line, tdi, tms, tck});
      chk(core_in, pad_in);
      chk(pad_out, core_out);
      chk(pad_oe_b, core_oe_b);
   endtask
   task automatic t_idcode();
      logic q;
      logic [31:0] cap;
      @(posedge clk);
      test_mode <= 1'b1;
      repeat (4) @(posedge clk);
      repeat (5) bst_tester_inst.step(1'b1, 1'b0, q);
      bst_tester_inst.step(1'b0, 1'b0, q);
      #1;
      chk(pin_oe_b, 4'hf);
      chk(pin_out[2:0], 3'h0);
      chk(func_in, 4'h0);
      bst_tester_inst.scan(1'b0, 32, 32'h0, cap);
      chk(cap, ID_VAL);
   endtask
   task automatic t_boundary();
      logic [31:0] cap;
      logic [23:0] exp;
      logic [7:0] upd_out;
      logic [7:0] upd_oe_b;
      logic [15:0] op;
      for (int i = 0; i < 8; i++)
      begin
         exp[3 * i +: 3] = {core_oe_b[i], core_out[i], pad_in[i]};
         upd_out[i] = PAT[3 * i + 1];
         upd_oe_b[i] = PAT[3 * i + 2];
      end
      bst_tester_inst.scan(1'b1, 16, {16'h0, bst_pkg::OP_SAMPLE}, cap);
      bst_tester_inst.scan(1'b0, 24, {8'h0, PAT}, cap);
      chk(cap, {8'h0, exp});
      chk(pad_out, core_out);
      // Preloaded cells must reach the pads under both pin-driving opcodes
      for (int k = 0; k < 2; k++)
      begin
         op = (k == 0) ? bst_pkg::OP_EXTEST : bst_pkg::OP_CLAMP;
         bst_tester_inst.scan(1'b1, 16, {16'h0, op}, cap);
         chk(pad_out, upd_out);
         chk(pad_oe_b, upd_oe_b);
      end
   endtask
   task automatic t_bypass();
      logic [15:0] ops [5];
      logic [31:0] cap;
      ops = '{bst_pkg::OP_BYPASS0, bst_pkg::OP_BYPASS1, bst_pkg::OP_CLAMP, bst_pkg::OP_HIGHZ, 16'h1234};
      foreach (ops[i])
      begin
         bst_tester_inst.scan(1'b1, 16, {16'h0, ops[i]}, cap);
         chk(cap, {16'h0, bst_pkg::IR_CAPTURE});
         bst_tester_inst.scan(1'b0, 4, 32'hb, cap);
         chk(cap, 32'h6);
         if (ops[i] == bst_pkg::OP_HIGHZ)
         begin
            chk(pad_oe_b, 8'hff);
            chk(pad_out, 8'h0);
         end
      end
   endtask
   task automatic t_private();
      logic q;
      logic [31:0] cap;
      bst_tester_inst.scan(1'b1, 16, {16'h0, bst_pkg::OP_INTERNAL_DATA_REGISTER_SELECT}, cap);
      chk(int_sel, 1'b1);
      bst_tester_inst.scan(1'b0, 8, 32'h5a, cap);
      chk(cap, {24'h0, bst_pkg::INT_DR_RESET});
      chk(int_dr, 8'h5a);
      bst_tester_inst.scan(1'b0, 8, 32'hc3, cap);
      chk(cap, 32'h5a);
      @(posedge clk);
      test_mode <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(int_sel, 1'b0);
      chk(pin_oe_b, func_oe_b);
      @(posedge clk);
      test_mode <= 1'b1;
      repeat (4) @(posedge clk);
      // Leaving test mode must have reset the controller and opcode
      bst_tester_inst.step(1'b0, 1'b0, q);
      bst_tester_inst.scan(1'b0, 32, 32'h0, cap);
      chk(cap, ID_VAL);
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_normal();
      t_idcode();
      t_boundary();
      t_bypass();
      t_private();
      tally_and_finish();
   end
   initial
   begin
      // Full run needs about 60 us
      #500us;
      failures++;
      tally_and_finish();
   end
endmodule
